/* pkg/iee_defines.svh */
/*
 Timing-free constants for the exception entry block: levels, vector
 numbers, bank count. Assumes inclusion by bare name.
*/
`ifndef IEE_DEFINES_SVH
`define IEE_DEFINES_SVH
`define IEE_NMI_LEVEL      5'h10
`define IEE_FIXED_LEVEL    5'h0f
`define IEE_NMI_MASK_WRITE 4'hf
`define IEE_VEC_NMI        8'h0b
`define IEE_VEC_BREAK      8'h0c
`define IEE_VEC_DEBUG      8'h0e
`define IEE_VEC_BANKOVF    8'h0f
`define IEE_VEC_GENILL     8'h04
`define IEE_VEC_SLOTILL    8'h06
`define IEE_VEC_DIVZERO    8'h09
`define IEE_VEC_DIVOVF     8'h0a
`define IEE_VEC_EXT0       8'h40
`define IEE_VEC_PIN0       8'h50
`define IEE_VEC_PERI0      8'h60
`define IEE_BANK_COUNT     5'h0f
`define IEE_STACK_STEP     32'h00000004
`define IEE_MASK_RESET     4'hf
`endif

/* pkg/iee_pkg.sv */
/*
 Types for the exception entry block. Assumes iee_defines.svh beside it.
*/
package iee_pkg;
	typedef enum logic [2:0] {
		IEE_IDLE,
		IEE_FETCH,
		IEE_PUSH_SR,
		IEE_PUSH_PC,
		IEE_BANK,
		IEE_JUMP
	} iee_state_t;
endpackage : iee_pkg

/* rtl/iee_exception_entry.sv */
/*
 Exception entry: interrupt priority resolution, mask test, vectoring,
 stacking of status word and program counter, bank save and overflow,
 instruction exceptions. Assumes a pipeline that holds while busy is high,
 a memory that answers memAck, and level requests held until taken.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iee_defines.svh"
// Contract
// - NMI level 16, unmaskable, always accepted
// - Break and debug requests fixed level 15
// - Other sources programmable 0..15 only
// - Eight external and eight pin-change inputs
// - Each source has its own vector
// - Highest pending priority wins
// - Maskable accepted only above mask field
// - Fetch vector, push status then PC
// - Bank save for maskable bank-using interrupts
// - No bank save for NMI, break, instructions
// - Banks full, accept bit 0: stack instead
// - Banks full, accept bit 1: overflow exception
// - Mask gets level; NMI writes 0xF
// - Jump to handler, no delay slot
// - Trap vectors by number, saves next PC
// - Illegal delay-slot instructions raise slot-illegal
// - Slot-illegal saves branch target
// - Undefined code raises general-illegal, saves own address
// - Divide by zero; signed minimum by minus one
// - Division exception saves division address
// - Requests after delayed branch held pending
module iee_exception_entry #(
	parameter int NPERI = 8
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                nmiReq,
	input  wire logic                breakReq,
	input  wire logic                debugReq,
	input  wire logic [7:0]          extReq,
	input  wire logic [7:0]          pinChangeReq,
	input  wire logic [NPERI-1:0]    periReq,
	input  wire logic [8*4-1:0]      extLevel,
	input  wire logic [3:0]          pinChangeLevel,
	input  wire logic [NPERI*4-1:0]  periLevel,
	input  wire logic                bankEnable,
	input  wire logic                bankOverflowAccept,
	input  wire logic [31:0]         vectorBase,
	input  wire logic                decodeValid,
	input  wire logic                afterDelayedBranch,
	input  wire logic                inDelaySlot,
	input  wire logic                instUndefined,
	input  wire logic                instWritesPc,
	input  wire logic                inst32,
	input  wire logic                instBankRestore,
	input  wire logic                instTrap,
	input  wire logic [7:0]          trapNumber,
	input  wire logic                instDivide,
	input  wire logic                divSigned,
	input  wire logic [31:0]         divDividend,
	input  wire logic [31:0]         divDivisor,
	input  wire logic [31:0]         instAddr,
	input  wire logic [31:0]         nextAddr,
	input  wire logic [31:0]         branchTarget,
	input  wire logic [31:0]         statusWord,
	input  wire logic [31:0]         stackPointer,
	input  wire logic                memAck,
	input  wire logic [31:0]         memRdata,
	output logic                     busy,
	output logic                     memRead,
	output logic                     memWrite,
	output logic [31:0]              memAddr,
	output logic [31:0]              memWdata,
	output logic                     bankSave,
	output logic [3:0]               bankSaveIndex,
	output logic [7:0]               bankSaveVector,
	output logic                     takeAck,
	output logic [7:0]               takenVector,
	output logic                     maskWrite,
	output logic [3:0]               maskValue,
	output logic [31:0]              spValue,
	output logic                     jumpValid,
	output logic [31:0]              jumpAddr,
	output logic [4:0]               bankUsed
);
	import iee_pkg::*;

	localparam int NSRC = 19 + NPERI;

	typedef struct packed {
		iee_state_t  state;
		logic [7:0]  vec;
		logic [31:0] savedPc;
		logic [31:0] handler;
		logic [31:0] sp;
		logic [3:0]  newMask;
		logic        doMask;
		logic        doBank;
		logic [4:0]  used;
		logic        pendOvf;
		logic        jump;
		logic        ack;
		logic        bank;
		logic [3:0]  bankIdx;
	} iee_regs_t;

	iee_regs_t   st_reg;
	iee_regs_t   st_next;
	logic        rstMeta;
	logic        rstSync;
	logic [4:0]  srcLevel [NSRC];
	logic [NSRC-1:0] srcReq;
	logic [7:0]  srcVec [NSRC];
	logic [NSRC-1:0] srcBanks;
	logic [4:0]  bestLevel;
	logic [7:0]  bestVec;
	logic        bestBanks;
	logic        bestFound;
	logic        intAccept;
	logic        slotIll;
	logic        genIll;
	logic        divZero;
	logic        divOvf;
	logic [3:0]  maskField;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	assign maskField = statusWord[7:4];

	// Source table: fixed levels first, then programmable ones
	assign srcReq[0] = nmiReq;
	assign srcLevel[0] = `IEE_NMI_LEVEL;
	assign srcVec[0] = `IEE_VEC_NMI;
	assign srcBanks[0] = 1'b0;
	assign srcReq[1] = breakReq;
	assign srcLevel[1] = `IEE_FIXED_LEVEL;
	assign srcVec[1] = `IEE_VEC_BREAK;
	assign srcBanks[1] = 1'b0;
	assign srcReq[2] = debugReq;
	assign srcLevel[2] = `IEE_FIXED_LEVEL;
	assign srcVec[2] = `IEE_VEC_DEBUG;
	assign srcBanks[2] = 1'b1;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gExt
			assign srcReq[3+g] = extReq[g];
			assign srcLevel[3+g] = {1'b0, extLevel[g*4 +: 4]};
			assign srcVec[3+g] = `IEE_VEC_EXT0 + 8'(g);
			assign srcBanks[3+g] = 1'b1;
			assign srcReq[11+g] = pinChangeReq[g];
			assign srcLevel[11+g] = {1'b0, pinChangeLevel};
			assign srcVec[11+g] = `IEE_VEC_PIN0 + 8'(g);
			assign srcBanks[11+g] = 1'b1;
		end
		for (g = 0; g < NPERI; g++) begin : gPeri
			assign srcReq[19+g] = periReq[g];
			assign srcLevel[19+g] = {1'b0, periLevel[g*4 +: 4]};
			assign srcVec[19+g] = `IEE_VEC_PERI0 + 8'(g);
			assign srcBanks[19+g] = 1'b1;
		end
	endgenerate

	// Strict greater-than keeps the lowest index on ties
	always_comb begin
		bestLevel = 5'h00;
		bestVec = 8'h00;
		bestBanks = 1'b0;
		bestFound = 1'b0;
		for (int i = 0; i < NSRC; i++) begin
			if (srcReq[i] && (!bestFound || srcLevel[i] > bestLevel)) begin
				bestFound = 1'b1;
				bestLevel = srcLevel[i];
				bestVec = srcVec[i];
				bestBanks = srcBanks[i];
			end
		end
	end

	// NMI bypasses the mask; others must exceed it
	assign intAccept = bestFound && (bestLevel == `IEE_NMI_LEVEL
		|| bestLevel > {1'b0, maskField});

	assign slotIll = inDelaySlot && (instUndefined || instWritesPc || inst32
		|| instBankRestore || instDivide);
	assign genIll = !inDelaySlot && instUndefined;
	assign divZero = instDivide && divDivisor == 32'h00000000;
	assign divOvf = instDivide && divSigned && divDividend == 32'h80000000
		&& divDivisor == 32'hffffffff;

	always_comb begin
		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.jump = 1'b0;
		st_next.bank = 1'b0;
		case (st_reg.state)
			IEE_IDLE: begin
				st_next.doMask = 1'b0;
				st_next.doBank = 1'b0;
				st_next.sp = stackPointer;
				if (decodeValid && slotIll) begin
					st_next.vec = `IEE_VEC_SLOTILL;
					st_next.savedPc = branchTarget;
					st_next.state = IEE_FETCH;
				end else if (decodeValid && genIll) begin
					st_next.vec = `IEE_VEC_GENILL;
					st_next.savedPc = instAddr;
					st_next.state = IEE_FETCH;
				end else if (decodeValid && (divZero || divOvf)) begin
					st_next.vec = divZero ? `IEE_VEC_DIVZERO
						: `IEE_VEC_DIVOVF;
					st_next.savedPc = instAddr;
					st_next.state = IEE_FETCH;
				end else if (decodeValid && instTrap) begin
					st_next.vec = trapNumber;
					st_next.savedPc = nextAddr;
					st_next.state = IEE_FETCH;
				end else if (decodeValid && !afterDelayedBranch
					&& st_reg.pendOvf) begin
					st_next.pendOvf = 1'b0;
					st_next.vec = `IEE_VEC_BANKOVF;
					st_next.savedPc = instAddr;
					st_next.state = IEE_FETCH;
				end else if (decodeValid && !afterDelayedBranch
					&& intAccept) begin
					st_next.vec = bestVec;
					st_next.savedPc = instAddr;
					st_next.doMask = 1'b1;
					st_next.newMask = bestLevel == `IEE_NMI_LEVEL
						? `IEE_NMI_MASK_WRITE : bestLevel[3:0];
					st_next.ack = 1'b1;
					if (bankEnable && bestBanks) begin
						if (st_reg.used < `IEE_BANK_COUNT)
							st_next.doBank = 1'b1;
						else if (bankOverflowAccept)
							st_next.pendOvf = 1'b1;
					end // Full and accept bit 0: stack only
					st_next.state = IEE_FETCH;
				end
			end
			IEE_FETCH: if (memAck) begin
				st_next.handler = memRdata;
				st_next.sp = st_reg.sp - `IEE_STACK_STEP;
				st_next.state = IEE_PUSH_SR;
			end
			IEE_PUSH_SR: if (memAck) begin
				st_next.sp = st_reg.sp - `IEE_STACK_STEP;
				st_next.state = IEE_PUSH_PC;
			end
			IEE_PUSH_PC: if (memAck) begin
				st_next.state = st_reg.doBank ? IEE_BANK : IEE_JUMP;
			end
			IEE_BANK: begin
				st_next.bank = 1'b1;
				st_next.bankIdx = st_reg.used[3:0];
				st_next.used = st_reg.used + 5'h01;
				st_next.state = IEE_JUMP;
			end
			IEE_JUMP: begin
				st_next.jump = 1'b1;
				st_next.state = IEE_IDLE;
			end
			default: st_next.state = IEE_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			st_reg <= '0;
			st_reg.state <= IEE_IDLE;
			st_reg.newMask <= `IEE_MASK_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy = st_reg.state != IEE_IDLE;
	assign memRead = st_reg.state == IEE_FETCH;
	assign memWrite = st_reg.state == IEE_PUSH_SR
		|| st_reg.state == IEE_PUSH_PC;
	assign memAddr = memRead ? vectorBase + {22'h0, st_reg.vec, 2'b00}
		: st_reg.sp;
	assign memWdata = st_reg.state == IEE_PUSH_SR ? statusWord
		: st_reg.savedPc;
	assign bankSave = st_reg.bank;
	assign bankSaveIndex = st_reg.bankIdx;
	assign bankSaveVector = st_reg.vec;
	assign takeAck = st_reg.ack;
	assign takenVector = st_reg.vec;
	assign maskWrite = st_reg.jump && st_reg.doMask;
	assign maskValue = st_reg.newMask;
	assign spValue = st_reg.sp;
	assign jumpValid = st_reg.jump;
	assign jumpAddr = st_reg.handler;
	assign bankUsed = st_reg.used;

	property p_nmi_taken;
		@(posedge clk) disable iff (!rstSync)
		(st_reg.state == IEE_IDLE && decodeValid && !afterDelayedBranch
			&& nmiReq && !slotIll && !genIll && !divZero && !divOvf
			&& !instTrap && !st_reg.pendOvf)
			|=> takeAck && takenVector == `IEE_VEC_NMI;
	endproperty
	a_nmi_taken: assert property (p_nmi_taken)
		else $error("NMI not taken");

	property p_mask_block;
		@(posedge clk) disable iff (!rstSync)
		takeAck && takenVector != `IEE_VEC_NMI |-> !$past(nmiReq);
	endproperty
	a_mask_block: assert property (p_mask_block)
		else $error("Maskable taken over NMI");

	property p_nmi_mask;
		@(posedge clk) disable iff (!rstSync)
		takeAck && takenVector == `IEE_VEC_NMI |-> maskValue == 4'hf;
	endproperty
	a_nmi_mask: assert property (p_nmi_mask)
		else $error("NMI mask value wrong");

	sequence s_push_sr;
		memWrite && st_reg.state == IEE_PUSH_SR
			&& memWdata == statusWord;
	endsequence
	property p_push_order;
		@(posedge clk) disable iff (!rstSync)
		(memRead && memAck) |=> s_push_sr;
	endproperty
	a_push_order: assert property (p_push_order)
		else $error("Status word not pushed first");

	property p_sp_step;
		@(posedge clk) disable iff (!rstSync)
		(memWrite && memAck && st_reg.state == IEE_PUSH_SR)
			|=> spValue == $past(spValue) - 32'h4;
	endproperty
	a_sp_step: assert property (p_sp_step)
		else $error("Stack pointer step wrong");

	property p_no_bank_nmi;
		@(posedge clk) disable iff (!rstSync)
		bankSave |-> bankSaveVector != `IEE_VEC_NMI
			&& bankSaveVector != `IEE_VEC_BREAK;
	endproperty
	a_no_bank_nmi: assert property (p_no_bank_nmi)
		else $error("Bank save on NMI or break");

	property p_jump_after_bank;
		@(posedge clk) disable iff (!rstSync)
		bankSave |=> jumpValid ##1 !busy;
	endproperty
	a_jump_after_bank: assert property (p_jump_after_bank)
		else $error("Jump missing after bank save");

	property p_bank_limit;
		@(posedge clk) disable iff (!rstSync)
		bankSave |-> bankUsed <= 5'h0f
			&& bankSaveIndex == $past(bankUsed[3:0]);
	endproperty
	a_bank_limit: assert property (p_bank_limit)
		else $error("Bank count overrun");

	property p_div_pc;
		@(posedge clk) disable iff (!rstSync)
		(st_reg.state == IEE_IDLE && decodeValid && !slotIll && !genIll
			&& divZero) |=> st_reg.savedPc == $past(instAddr)
			&& st_reg.vec == `IEE_VEC_DIVZERO;
	endproperty
	a_div_pc: assert property (p_div_pc)
		else $error("Division saved PC wrong");

	property p_hold_after_branch;
		@(posedge clk) disable iff (!rstSync)
		(st_reg.state == IEE_IDLE && afterDelayedBranch) |=> !takeAck;
	endproperty
	a_hold_after_branch: assert property (p_hold_after_branch)
		else $error("Interrupt taken after delayed branch");
endmodule : iee_exception_entry
`default_nettype wire

/* testbench/iee_mem_model.sv */
/*
 Vector table and stack memory facing the exception entry block.
 Assumes one request at a time, held until memAck is seen.
*/
`timescale 1ns/1ps
`default_nettype none
module iee_mem_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        slowMode,
	input  wire logic        memRead,
	input  wire logic        memWrite,
	input  wire logic [31:0] memAddr,
	input  wire logic [31:0] memWdata,
	output logic             memAck,
	output logic [31:0]      memRdata,
	output logic [31:0]      rdAddr,
	output logic [31:0]      wrAddr [2],
	output logic [31:0]      wrData [2]
);
	logic [1:0] cnt;
	logic       wIdx;
	// Data toggles when idle so a stale read never looks valid
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memAck <= 1'b0;
			cnt <= 2'h0;
			memRdata <= 32'h0;
			wIdx <= 1'b0;
		end else begin
			memAck <= 1'b0;
			memRdata <= ~memRdata;
			if ((memRead || memWrite) && !memAck) begin
				if (cnt < (slowMode ? 2'h3 : 2'h0)) begin
					cnt <= cnt + 2'h1;
				end else begin
					cnt <= 2'h0;
					memAck <= 1'b1;
					if (memRead) begin
						memRdata <= memAddr ^ 32'h5a5a0000;
						rdAddr <= memAddr;
						wIdx <= 1'b0;
					end else begin
						wrAddr[wIdx] <= memAddr;
						wrData[wIdx] <= memWdata;
						wIdx <= ~wIdx;
					end
				end
			end
		end
	end
endmodule : iee_mem_model
`default_nettype wire

/* testbench/test_iee_exception_entry.sv */
/*
 Self-checking bench for the exception entry block.
 Assumes iee_defines.svh and the memory model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iee_defines.svh"
module test_iee_exception_entry;
	localparam logic [31:0] SP = 32'h00001000;
	localparam logic [31:0] VB = 32'h00000800;
	logic clk = 1'b0, rst_n = 1'b0, slowMode = 1'b0;
	logic nmiReq = 1'b0, breakReq = 1'b0, debugReq = 1'b0;
	logic [7:0] extReq = 8'h0, pinChangeReq = 8'h0, periReq = 8'h0;
	logic [31:0] extLevel = 32'h0, periLevel = 32'h0, vectorBase = VB;
	logic [3:0] pinChangeLevel = 4'h0;
	logic bankEnable = 1'b1, bankOverflowAccept = 1'b0, divSigned = 1'b0;
	logic decodeValid = 1'b0, afterDelayedBranch = 1'b0, inDelaySlot = 1'b0;
	logic instUndefined = 1'b0, instWritesPc = 1'b0, inst32 = 1'b0;
	logic instBankRestore = 1'b0, instTrap = 1'b0, instDivide = 1'b0;
	logic [7:0] trapNumber = 8'h0;
	logic [31:0] divDividend = 32'h0, divDivisor = 32'h0, statusWord = 32'h0;
	logic [31:0] instAddr = 32'h2000, nextAddr = 32'h2000;
	logic [31:0] branchTarget = 32'h3000, stackPointer = SP;
	logic busy, memRead, memWrite, memAck, bankSave, takeAck;
	logic maskWrite, jumpValid;
	logic [31:0] memAddr, memWdata, memRdata, spValue, jumpAddr, rdAddr;
	logic [31:0] wrAddr [2];
	logic [31:0] wrData [2];
	logic [3:0] bankSaveIndex, maskValue;
	logic [7:0] bankSaveVector, takenVector, ackVec;
	logic [4:0] bankUsed;
	int badCount = 0, checks = 0, bankCnt = 0, ackCnt = 0, banks = 0;

	iee_exception_entry i_dut (.clk, .rst_n, .nmiReq, .breakReq, .debugReq,
		.extReq, .pinChangeReq, .periReq, .extLevel, .pinChangeLevel,
		.periLevel, .bankEnable, .bankOverflowAccept, .vectorBase,
		.decodeValid, .afterDelayedBranch, .inDelaySlot, .instUndefined,
		.instWritesPc, .inst32, .instBankRestore, .instTrap, .trapNumber,
		.instDivide, .divSigned, .divDividend, .divDivisor, .instAddr,
		.nextAddr, .branchTarget, .statusWord, .stackPointer, .memAck,
		.memRdata, .busy, .memRead, .memWrite, .memAddr, .memWdata,
		.bankSave, .bankSaveIndex, .bankSaveVector, .takeAck, .takenVector,
		.maskWrite, .maskValue, .spValue, .jumpValid, .jumpAddr, .bankUsed);
	iee_mem_model i_mem (.clk, .rst_n, .slowMode, .memRead, .memWrite,
		.memAddr, .memWdata, .memAck, .memRdata, .rdAddr, .wrAddr, .wrData);

	always #5 clk = ~clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	always @(negedge clk) begin
		if (takeAck === 1'b1) begin
			ackCnt++;
			ackVec = takenVector;
		end
		if (bankSave === 1'b1) begin
			bankCnt++;
			chk(32'(bankSaveVector), 32'(ackVec));
			chk(32'(bankSaveIndex), 32'(banks));
		end
	end

	// Sources hold their level until any request is taken, then all clear at once
	always @(posedge clk) begin
		if (takeAck === 1'b1) begin
			{nmiReq, breakReq, debugReq} <= 3'h0;
			{extReq, pinChangeReq, periReq} <= 24'h0;
		end
	end

	task automatic entry(input logic [7:0] v, input logic [31:0] pc,
		input logic intr, input logic [3:0] m, input logic bk);
		int n;
		bankCnt = 0;
		ackCnt = 0;
		@(posedge clk);
		decodeValid <= 1'b1;
		for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge clk);
		@(posedge clk);
		decodeValid <= 1'b0;
		{instUndefined, instWritesPc, inst32, instBankRestore} <= 4'h0;
		{instTrap, instDivide, inDelaySlot} <= 3'h0;
		for (n = 0; n < 200 && jumpValid !== 1'b1; n++) @(negedge clk);
		chk(32'(jumpValid), 32'h1);
		chk(rdAddr, VB + 32'(v) * 4);
		chk(jumpAddr, (VB + 32'(v) * 4) ^ 32'h5a5a0000);
		chk(wrAddr[0], SP - 4);
		chk(wrData[0], statusWord);
		chk(wrAddr[1], SP - 8);
		chk(wrData[1], pc);
		chk(spValue, SP - 8);
		if (v != `IEE_VEC_BANKOVF) chk(32'(maskWrite), 32'(intr));
		if (intr) chk(32'(ackVec), 32'(v));
		chk(32'(ackCnt), 32'(intr));
		chk(32'(bankCnt), 32'(bk));
		banks += int'(bk);
		@(negedge clk);
		chk(32'(busy), 32'h0);
		if (intr) chk(32'(maskValue), 32'(m));
		@(posedge clk);
	endtask : entry

	// Holds a decode for a while and expects no entry at all
	task automatic refuse(input int cyc);
		@(posedge clk);
		decodeValid <= 1'b1;
		repeat (cyc) begin
			@(negedge clk);
			chk(32'(busy), 32'h0);
		end
		@(posedge clk);
		decodeValid <= 1'b0;
	endtask : refuse

	task automatic test_fixed();
		statusWord <= 32'hf0;
		nmiReq <= 1'b1;
		entry(`IEE_VEC_NMI, 32'h2000, 1'b1, 4'hf, 1'b0);
		statusWord <= 32'he0;
		{breakReq, debugReq} <= 2'h3;
		entry(`IEE_VEC_BREAK, 32'h2000, 1'b1, 4'hf, 1'b0);
		debugReq <= 1'b1;
		entry(`IEE_VEC_DEBUG, 32'h2000, 1'b1, 4'hf, 1'b1);
		debugReq <= 1'b1;
		statusWord <= 32'hf0;
		refuse(4);
		debugReq <= 1'b0;
	endtask : test_fixed

	task automatic test_levels();
		{extLevel, extReq, statusWord} <= {32'h5, 8'h1, 32'h50};
		refuse(4);
		statusWord <= 32'h40;
		entry(`IEE_VEC_EXT0, 32'h2000, 1'b1, 4'h5, 1'b1);
		{extLevel, pinChangeLevel, periLevel} <= {32'h930, 4'h9, 32'ha};
		{statusWord, extReq, pinChangeReq, periReq} <= {32'h0, 24'h060101};
		entry(`IEE_VEC_PERI0, 32'h2000, 1'b1, 4'ha, 1'b1);
		{extReq, pinChangeReq, bankEnable} <= {16'h0601, 1'b0};
		entry(`IEE_VEC_EXT0 + 8'h2, 32'h2000, 1'b1, 4'h9, 1'b0);
		{extLevel, extReq, afterDelayedBranch, bankEnable} <= {32'hf, 8'h1,
			2'h3};
		refuse(4);
		afterDelayedBranch <= 1'b0;
		entry(`IEE_VEC_EXT0, 32'h2000, 1'b1, 4'hf, 1'b1);
	endtask : test_levels

	task automatic test_inst();
		int i;
		{slowMode, nextAddr, instTrap, trapNumber} <= {1'b1, 32'h2002, 9'h121};
		entry(8'h21, 32'h2002, 1'b0, 4'h0, 1'b0);
		for (i = 0; i < 5; i++) begin
			{inDelaySlot, divDivisor} <= {1'b1, 32'h1};
			{instUndefined, instWritesPc, inst32, instBankRestore,
				instDivide} <= 5'h10 >> i;
			entry(`IEE_VEC_SLOTILL, 32'h3000, 1'b0, 4'h0, 1'b0);
		end
		instUndefined <= 1'b1;
		entry(`IEE_VEC_GENILL, 32'h2000, 1'b0, 4'h0, 1'b0);
		for (i = 0; i < 2; i++) begin
			{instDivide, divSigned, divDividend, divDivisor} <= {1'(1), 1'(i),
				32'h7, 32'h0};
			entry(`IEE_VEC_DIVZERO, 32'h2000, 1'b0, 4'h0, 1'b0);
		end
		{instDivide, divSigned} <= 2'h3;
		{divDividend, divDivisor} <= {32'h80000000, 32'hffffffff};
		entry(`IEE_VEC_DIVOVF, 32'h2000, 1'b0, 4'h0, 1'b0);
		{instDivide, divSigned} <= 2'h2;
		refuse(3);
		{instDivide, slowMode, nextAddr} <= {2'h0, 32'h2000};
	endtask : test_inst

	task automatic test_banks();
		int g;
		{extLevel, pinChangeLevel, statusWord} <= {32'h33333333, 4'h3, 32'h0};
		for (g = 0; g < 16; g++) begin
			if (g < 8) extReq <= 8'h1 << g;
			else pinChangeReq <= 8'h1 << (g - 8);
			entry(g < 8 ? `IEE_VEC_EXT0 + 8'(g) : `IEE_VEC_PIN0 + 8'(g - 8),
				32'h2000, 1'b1, 4'h3, banks < 15);
		end
		chk(32'(bankUsed), 32'hf);
		{bankOverflowAccept, extReq} <= {1'b1, 8'h1};
		entry(`IEE_VEC_EXT0, 32'h2000, 1'b1, 4'h3, 1'b0);
		afterDelayedBranch <= 1'b1;
		refuse(3);
		afterDelayedBranch <= 1'b0;
		entry(`IEE_VEC_BANKOVF, 32'h2000, 1'b0, 4'h0, 1'b0);
	endtask : test_banks

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		test_fixed();
		test_levels();
		test_inst();
		test_banks();
		test_done();
	end

	// Whole run is well under a thousand cycles
	initial begin
		#300000;
		badCount++;
		test_done();
	end
endmodule : test_iee_exception_entry
`default_nettype wire
